// ===== core/apdc_auto_power_down_ctrl.sv
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

module apdc_auto_power_down_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Device side
    input  wire logic        module_reset,
    input  wire logic        addr_latch_strobe,
    input  wire logic        common_clock_input,
    input  wire logic        chip_select_in_n,
    input  wire logic        main_flash_sel_raw,
    input  wire logic        boot_flash_sel_raw,
    input  wire logic        sram_sel_raw,
    input  wire logic        ctrl_reg_sel_raw,
    input  wire logic [15:0] host_addr_in,
    input  wire logic [7:0]  host_data_in,
    output logic             shutdown_indicator,
    output logic             logic_bus_shutdown_term,
    output logic             logic_bus_clock_term,
    output logic             addr_data_buf_en,
    output logic [15:0]      buf_addr,
    output logic [7:0]       buf_data,
    output logic             main_flash_selects,
    output logic             boot_flash_selects,
    output logic             sram_select,
    output logic             ctrl_reg_select,
    output logic             code_mem_online,
    output logic             mem_standby,
    output logic             logic_array_standby
);

    // ==========================================
    // Register file
    // ==========================================
    logic [7:0] power_mode_ctrl_first_r;
    logic [7:0] power_mode_ctrl_fourth_r;
    logic       ack_r;
    logic       wr_go;
    logic       rd_go;

    // One wait state: answer on the edge after a request is seen
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // First mode register: power-up (srst) clears it, writes load it; module reset leaves it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            power_mode_ctrl_first_r <= apdc_pkg::MODE_RESET_VAL;
        end else if (wr_go && avs_byteenable[0] &&
                     avs_address == apdc_pkg::REG_MODE_FIRST_OFS) begin
            power_mode_ctrl_first_r <= avs_writedata[7:0];
        end
    end

    // Force bit: writes can only set it; reset is the sole clear
    logic force_shutdown_bit;
    logic module_reset_rise;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            power_mode_ctrl_fourth_r <= apdc_pkg::MODE_RESET_VAL;
        end else if (wr_go && avs_byteenable[0] &&
                     avs_address == apdc_pkg::REG_MODE_FOURTH_OFS) begin
            // Zero writes never clear; a set beats a same-cycle reset rise
            power_mode_ctrl_fourth_r <= avs_writedata[7:0]
                | {6'h00,
                   power_mode_ctrl_fourth_r[1] & ~module_reset_rise,
                   1'b0};
        end else if (module_reset_rise) begin
            power_mode_ctrl_fourth_r[apdc_pkg::FORCE_BIT] <= 1'b0;
        end
    end

    assign force_shutdown_bit =
        power_mode_ctrl_fourth_r[apdc_pkg::FORCE_BIT];

    logic auto_idle_shutdown;
    assign auto_idle_shutdown =
        power_mode_ctrl_first_r[apdc_pkg::AUTO_EN_BIT];

    // ==========================================
    // Edge detection
    // ==========================================
    logic clk_rise;
    logic csel_fall;

    apdc_edge_track u_clk_edge (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .level_in (common_clock_input),
        .rise     (clk_rise),
        .fall     (),
        .toggle   ()
    );

    apdc_edge_track u_csel_edge (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .level_in (chip_select_in_n),
        .rise     (),
        .fall     (csel_fall),
        .toggle   ()
    );

    apdc_edge_track u_rst_edge (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .level_in (module_reset),
        .rise     (module_reset_rise),
        .fall     (),
        .toggle   ()
    );

    // Strobe activity seen per sys clock, so short pulses between
    // common clock edges still count as activity
    logic strobe_toggle;

    apdc_edge_track u_strobe_edge (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .level_in (addr_latch_strobe),
        .rise     (),
        .fall     (),
        .toggle   (strobe_toggle)
    );

    // Activity since last common clock period
    logic activity_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            activity_r <= 1'b0;
        end else if (clk_rise) begin
            activity_r <= strobe_toggle;
        end else if (strobe_toggle) begin
            activity_r <= 1'b1;
        end
    end

    logic period_active;
    assign period_active = activity_r | strobe_toggle;

    // ==========================================
    // Idle counter and indicator
    // ==========================================
    logic [apdc_pkg::IDLE_CNT_W-1:0] idle_cnt_r;
    logic                            pd_r;
    logic                            wake;
    logic                            wake_r;

    // Strobe pulsing again also wakes from forced entry only if cleared
    assign wake = strobe_toggle | csel_fall | module_reset_rise;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            idle_cnt_r <= '0;
        end else if (wake && pd_r) begin
            idle_cnt_r <= '0;
        end else if (!auto_idle_shutdown) begin
            idle_cnt_r <= '0;
        end else if (clk_rise) begin
            if (period_active) begin
                idle_cnt_r <= '0;
            end else if (idle_cnt_r != apdc_pkg::IDLE_CNT_MAX) begin
                idle_cnt_r <= idle_cnt_r + 4'h1;
            end
        end
    end

    // Indicator holds until a wake; force keeps it regardless of counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pd_r <= 1'b0;
        end else if (force_shutdown_bit && !module_reset_rise) begin
            pd_r <= 1'b1;
        end else if (wake) begin
            pd_r <= 1'b0;
        end else if (auto_idle_shutdown &&
                     idle_cnt_r == apdc_pkg::IDLE_CNT_MAX) begin
            pd_r <= 1'b1;
        end
    end

    // Write of force bit shows at once, without the counter
    logic force_now;
    assign force_now = wr_go && avs_byteenable[0]
        && avs_address == apdc_pkg::REG_MODE_FOURTH_OFS
        && avs_writedata[apdc_pkg::FORCE_BIT];

    // Force bit itself keeps the indicator up in the cycle before pd_r
    // catches up, so there is no one-cycle dip after the write
    assign shutdown_indicator = pd_r | force_shutdown_bit
        | force_now;

    // ==========================================
    // Shutdown effects
    // ==========================================
    assign addr_data_buf_en        = ~shutdown_indicator;
    assign logic_bus_shutdown_term = shutdown_indicator;
    // Clock block bit only hides the clock from the logic bus
    assign logic_bus_clock_term = common_clock_input
        & ~power_mode_ctrl_first_r[apdc_pkg::CLK_BLOCK_BIT];
    assign main_flash_selects = main_flash_sel_raw & ~shutdown_indicator
        & ~chip_select_in_n;
    assign boot_flash_selects = boot_flash_sel_raw & ~shutdown_indicator
        & ~chip_select_in_n;
    assign sram_select = sram_sel_raw & ~shutdown_indicator
        & ~chip_select_in_n;
    assign ctrl_reg_select = ctrl_reg_sel_raw & ~shutdown_indicator
        & ~chip_select_in_n;
    assign code_mem_online = ~shutdown_indicator;
    assign mem_standby     = shutdown_indicator;
    // Low-speed mode plus quiet non-address inputs
    assign logic_array_standby = shutdown_indicator
        & power_mode_ctrl_first_r[apdc_pkg::TURBO_OFF_BIT]
        & ~wake_r & ~strobe_toggle;

    // Input buffers freeze the last bus value while shut down;
    // nothing here touches the host core's own ports
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            buf_addr <= 16'h0000;
            buf_data <= 8'h00;
        end else if (!shutdown_indicator) begin
            buf_addr <= host_addr_in;
            buf_data <= host_data_in;
        end
    end

    // ==========================================
    // Read path
    // ==========================================
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            unique case (avs_address)
                apdc_pkg::REG_MODE_FIRST_OFS:
                    avs_readdata <= {24'h000000, power_mode_ctrl_first_r};
                apdc_pkg::REG_MODE_FOURTH_OFS:
                    avs_readdata <= {24'h000000, power_mode_ctrl_fourth_r};
                apdc_pkg::REG_STATUS_OFS:
                    avs_readdata <= {26'h0, pd_r,
                                     force_shutdown_bit, idle_cnt_r};
                default:
                    avs_readdata <= apdc_pkg::UNMAPPED_RDATA;
            endcase
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    counter_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        !auto_idle_shutdown |=> idle_cnt_r == 4'h0)
        else $error("idle counter moved while disabled");
    count_step_a: assert property (@(posedge clk_sys) disable iff (srst)
        auto_idle_shutdown && clk_rise && !period_active && !pd_r
        && idle_cnt_r < 4'hF
        |=> idle_cnt_r == $past(idle_cnt_r) + 4'h1)
        else $error("idle counter failed to step");
    auto_entry_a: assert property (@(posedge clk_sys) disable iff (srst)
        auto_idle_shutdown && idle_cnt_r == 4'hF && !wake
        |=> pd_r)
        else $error("no shutdown at full count");
    activity_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        clk_rise && period_active |=> idle_cnt_r == 4'h0)
        else $error("activity did not clear counter");
    select_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        shutdown_indicator |-> !(main_flash_selects | boot_flash_selects
        | sram_select | ctrl_reg_select))
        else $error("select active in shutdown");
    force_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        force_shutdown_bit && !module_reset_rise |=> pd_r)
        else $error("force bit did not hold shutdown");
    force_sticky_a: assert property (@(posedge clk_sys) disable iff (srst)
        force_shutdown_bit && !module_reset_rise
        |=> force_shutdown_bit)
        else $error("force bit cleared without reset");
    wake_csel_a: assert property (@(posedge clk_sys) disable iff (srst)
        pd_r && !force_shutdown_bit && csel_fall |=> !pd_r)
        else $error("chip select fall did not wake");
    wake_strobe_a: assert property (@(posedge clk_sys) disable iff (srst)
        pd_r && !force_shutdown_bit && strobe_toggle |=> !pd_r)
        else $error("strobe activity did not wake");
    force_show_a: assert property (@(posedge clk_sys) disable iff (srst)
        force_now |=> shutdown_indicator)
        else $error("forced shutdown dropped after write");
    reset_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        module_reset_rise && !force_now |=> !force_shutdown_bit)
        else $error("reset rise left force bit set");
    buf_freeze_a: assert property (@(posedge clk_sys) disable iff (srst)
        shutdown_indicator
        |=> {buf_addr, buf_data} == $past({buf_addr, buf_data}))
        else $error("input buffers moved in shutdown");

endmodule

// ===== core/apdc_edge_track.sv
`timescale 1ns/1ps

// ==========================================
// Edge tracker for synchronous levels
// ==========================================
module apdc_edge_track (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic level_in,
    output logic      rise,
    output logic      fall,
    output logic      toggle
);

    logic prev_r;

    // Previous sample; reset value 0, so no edge fakes at start from a low level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_in;
        end
    end

    assign rise   = level_in & ~prev_r;
    assign fall   = ~level_in & prev_r;
    assign toggle = level_in ^ prev_r;

endmodule

// ===== core/apdc_pkg.sv
package apdc_pkg;

    // ==========================================
    // Register map (word byte addresses)
    // ==========================================
    localparam logic [3:0] REG_MODE_FIRST_OFS  = 4'h0;
    localparam logic [3:0] REG_MODE_FOURTH_OFS = 4'h4;
    localparam logic [3:0] REG_STATUS_OFS      = 4'h8;
    localparam logic [3:0] REG_SELECTS_OFS     = 4'hC;

    // Field positions
    localparam int AUTO_EN_BIT     = 1;
    localparam int TURBO_OFF_BIT   = 3;
    localparam int CLK_BLOCK_BIT   = 4;
    localparam int FORCE_BIT       = 1;

    // Reset values
    localparam logic [7:0] MODE_RESET_VAL = 8'h00;

    // Idle counter
    localparam int IDLE_CNT_W = 4;
    localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_MAX = 4'hF;

    // Unmapped read answer
    localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

endpackage

// ===== verification/apdc_host_model.sv
`timescale 1ns/1ps

// ==========================================
// Host core strobe and common clock source
// ==========================================
module apdc_host_model (
    input  wire logic clk_sys,
    input  wire logic clk_run,
    input  wire logic strobe_run,
    output logic      common_clock_input,
    output logic      addr_latch_strobe
);
    logic [2:0] div_r;
    logic [2:0] gap_r;

    initial begin
        div_r = 3'h0;
        gap_r = 3'h0;
        common_clock_input = 1'b0;
        addr_latch_strobe = 1'b0;
    end

    // Eight system cycles a period; stands still while stopped
    always @(posedge clk_sys) begin
        if (clk_run) begin
            div_r <= div_r + 3'h1;
            common_clock_input <= div_r[2];
        end
    end

    // One strobe change per period, far below 15 idle periods
    always @(posedge clk_sys) begin
        gap_r <= strobe_run ? gap_r + 3'h1 : 3'h0;
        if (strobe_run && gap_r == 3'h0) begin
            addr_latch_strobe <= !addr_latch_strobe;
        end
    end
endmodule

// ===== verification/auto_power_down_ctrl_test.sv
`timescale 1ns/1ps

module auto_power_down_ctrl_test;
    logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        module_reset, chip_select_in_n, sel_raw;
    logic        addr_latch_strobe, common_clock_input, clk_run, strobe_run;
    logic [15:0] host_addr_in, buf_addr;
    logic [7:0]  host_data_in, buf_data;
    logic        shutdown_indicator, logic_bus_shutdown_term;
    logic        logic_bus_clock_term, addr_data_buf_en;
    logic        main_flash_selects, boot_flash_selects, sram_select;
    logic        ctrl_reg_select, code_mem_online, mem_standby;
    logic        logic_array_standby;
    int          errors, total_checks;

    // ==========================================
    // Clock, design and host model
    // ==========================================
    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    apdc_auto_power_down_ctrl apdc_auto_power_down_ctrl_inst (
        .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .module_reset(module_reset), .addr_latch_strobe(addr_latch_strobe),
        .common_clock_input(common_clock_input),
        .chip_select_in_n(chip_select_in_n),
        .main_flash_sel_raw(sel_raw), .boot_flash_sel_raw(sel_raw),
        .sram_sel_raw(sel_raw), .ctrl_reg_sel_raw(sel_raw),
        .host_addr_in(host_addr_in), .host_data_in(host_data_in),
        .shutdown_indicator(shutdown_indicator),
        .logic_bus_shutdown_term(logic_bus_shutdown_term),
        .logic_bus_clock_term(logic_bus_clock_term),
        .addr_data_buf_en(addr_data_buf_en), .buf_addr(buf_addr),
        .buf_data(buf_data), .main_flash_selects(main_flash_selects),
        .boot_flash_selects(boot_flash_selects), .sram_select(sram_select),
        .ctrl_reg_select(ctrl_reg_select), .code_mem_online(code_mem_online),
        .mem_standby(mem_standby), .logic_array_standby(logic_array_standby)
    );

    apdc_host_model apdc_host_model_inst (
        .clk_sys(clk_sys), .clk_run(clk_run), .strobe_run(strobe_run),
        .common_clock_input(common_clock_input),
        .addr_latch_strobe(addr_latch_strobe)
    );

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic tally_and_finish();
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t mismatch got %h want %h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Rising common clock edges as the design samples them
    task automatic rises(input int k);
        int c;
        int t;
        logic p;
        c = 0;
        t = 0;
        p = common_clock_input;
        while (c < k) begin
            @(posedge clk_sys);
            t++;
            if (common_clock_input && !p) c++;
            p = common_clock_input;
            if (t > 2000) begin
                errors++;
                tally_and_finish();
            end
        end
    endtask

    // Held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q & m, e);
    endtask

    // Buffers, selects, code memory, standby and logic term together
    task automatic pdchk(input logic e);
        chk({23'h0, shutdown_indicator, logic_bus_shutdown_term,
             addr_data_buf_en, main_flash_selects, boot_flash_selects,
             sram_select, ctrl_reg_select, code_mem_online, mem_standby},
            {23'h0, e, e, !e, !e, !e, !e, !e, !e, e});
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset();
        rdchk(4'h0, 32'hFFFFFFFF, 32'h0);
        rdchk(4'h4, 32'hFFFFFFFF, 32'h0);
        rdchk(4'h8, 32'hFFFFFFFF, 32'h0);
        rdchk(4'hC, 32'hFFFFFFFF, 32'h0);
        pdchk(1'b0);
    endtask

    task automatic t_disabled();
        rises(20);
        rdchk(4'h8, 32'hFFFFFFFF, 32'h0);
    endtask

    // Enable with the clock parked so no period straddles the write
    task automatic t_auto();
        clk_run <= 1'b0;
        wr(4'h0, 8'h1A);
        clk_run <= 1'b1;
        rises(14);
        tick(3);
        pdchk(1'b0);
        chk({31'h0, logic_bus_clock_term}, 32'h0);
        rises(1);
        tick(3);
        pdchk(1'b1);
        chk({31'h0, logic_array_standby}, 32'h1);
        host_addr_in <= 16'hBEEF;
        host_data_in <= 8'hC3;
        tick(3);
        chk({8'h00, buf_data, buf_addr}, 32'h005A_1234);
        rises(3);
        rdchk(4'h8, 32'h3F, 32'h2F);
    endtask

    // Strobe change, chip-select fall, module reset rise
    task automatic t_wake();
        for (int k = 0; k < 3; k++) begin
            rises(16);
            tick(3);
            pdchk(1'b1);
            if (k == 0) strobe_run <= 1'b1;
            if (k == 1) chip_select_in_n <= 1'b1;
            if (k == 2) module_reset <= 1'b1;
            tick(2);
            strobe_run <= 1'b0;
            chip_select_in_n <= 1'b0;
            module_reset <= 1'b0;
            tick(4);
            pdchk(1'b0);
        end
        chk({8'h00, buf_data, buf_addr}, 32'h00C3_BEEF);
        rdchk(4'h0, 32'hFF, 32'h1A);
    endtask

    task automatic t_activity();
        strobe_run <= 1'b1;
        rises(30);
        pdchk(1'b0);
        strobe_run <= 1'b0;
    endtask

    task automatic t_force();
        wr(4'h0, 8'h00);
        clk_run <= 1'b0;
        wr(4'h4, 8'h02);
        // Host powers itself down: strobe stays quiet
        strobe_run <= 1'b0;
        tick(1);
        pdchk(1'b1);
        rdchk(4'h8, 32'h30, 32'h30);
        wr(4'h0, 8'h02);
        clk_run <= 1'b1;
        strobe_run <= 1'b1;
        rises(4);
        pdchk(1'b1);
        wr(4'h4, 8'h00);
        chip_select_in_n <= 1'b1;
        tick(2);
        chip_select_in_n <= 1'b0;
        tick(3);
        pdchk(1'b1);
        rdchk(4'h4, 32'hFF, 32'h02);
        strobe_run <= 1'b0;
        module_reset <= 1'b1;
        tick(3);
        pdchk(1'b0);
        rdchk(4'h4, 32'hFF, 32'h00);
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        errors = 0;
        total_checks = 0;
        srst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        module_reset = 1'b0;
        chip_select_in_n = 1'b0;
        sel_raw = 1'b1;
        host_addr_in = 16'h1234;
        host_data_in = 8'h5A;
        clk_run = 1'b1;
        strobe_run = 1'b0;
        tick(5);
        srst <= 1'b0;
        t_reset();
        t_disabled();
        t_auto();
        t_wake();
        t_activity();
        t_force();
        tally_and_finish();
    end
endmodule
